// ==== rtl/tpm_bcd_conv.sv ====
// Serial decimal-to-binary converter for all switch sets in parallel
`timescale 1ns/100ps
`default_nettype none
module tpm_bcd_conv
   import tpm_pkg::*;
#(
   parameter int NS = TPM_NUM_SETS_DEF,
   parameter int ND = TPM_DIGITS_DEF
) (
   input wire logic clk,
   input wire logic nrst,
   tpm_conv_if.cnv conv
);
   typedef struct packed {
      logic busy;
      logic done;
      logic [3:0] cnt;
      logic [NS-1:0][ND-1:0][3:0] snap;
      logic [NS-1:0][TPM_MAG_W-1:0] acc;
   } tpm_conv_state_t;

   tpm_conv_state_t q, d;

   always_comb begin
      logic [3:0] idx;
      idx = 4'(ND - 1) - q.cnt;
      d = q;
      d.done = 1'b0;
      if (!q.busy && conv.start) begin
         // Snapshot: switch moves during conversion are ignored
         d.busy = 1'b1;
         d.cnt = 4'h0;
         d.snap = conv.digits;
         d.acc = '0;
      end else if (q.busy) begin
         for (int s = 0; s < NS; s++) begin
            d.acc[s] = TPM_MAG_W'({q.acc[s], 3'b000}) + TPM_MAG_W'({q.acc[s], 1'b0})
               + TPM_MAG_W'(q.snap[s][idx]);
         end
         d.cnt = q.cnt + 4'h1;
         if (q.cnt == 4'(ND - 1)) begin
            d.busy = 1'b0;
            d.done = 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign conv.busy = q.busy;
   assign conv.done = q.done;
   assign conv.mag = q.acc;
endmodule
`default_nettype wire

// ==== rtl/tpm_conv_if.sv ====
// Handshake between capture control and the digit converter
`timescale 1ns/100ps
`default_nettype none
interface tpm_conv_if #(
   parameter int NS = 4,
   parameter int ND = 9,
   parameter int MW = 30
);
   logic start;
   logic busy;
   logic done;
   logic [NS-1:0][ND-1:0][3:0] digits;
   logic [NS-1:0][MW-1:0] mag;
   modport ctl (output start, output digits, input busy, input done, input mag);
   modport cnv (input start, input digits, output busy, output done, output mag);
endinterface
`default_nettype wire

// ==== rtl/tpm_perm_map.sv ====
// Decoder from map code to the output index of each switch set
`timescale 1ns/100ps
`default_nettype none
module tpm_perm_map
   import tpm_pkg::*;
(
   input wire logic [4:0] code,
   output logic [TPM_NUM_OUT-1:0][1:0] dest,
   output logic valid
);
   // Only codes below 24 are permutations
   assign valid = (code < 5'(TPM_MAP_CODES));

   for (genvar g = 0; g < TPM_NUM_OUT; g++) begin : gSet
      assign dest[g] = valid ? TPM_MAP_TABLE[code][7-2*g -: 2] : 2'(g);
   end
endmodule
`default_nettype wire

// ==== rtl/tpm_pkg.sv ====
// Constants, register map and permutation table for the thumbwheel preset mapper
// Operation
// - Relays follow the four high-speed outputs exactly
// - Rows hold up to nine digits
// - Two or four switch sets per variant
// - Capture all sets automatically after reset
// - Later changes apply only on refresh command
// - Set values are positive by default
// - Sign mask bit n negates set n+1
// - Default routes set n to output n
// - Map code 0-23 selects a permutation
// - Codes 0-11 follow the first permutation table
// - Codes 12-23 follow the second permutation table
// - Sum mode: outputs 3-4 compare counter sum
// - Thresholds also serve as preset load source
package tpm_pkg;
   localparam int TPM_NUM_SETS_DEF = 4;
   localparam int TPM_DIGITS_DEF = 9;
   localparam int TPM_MAX_DIGITS = 9;
   localparam int TPM_ROW_POSITIONS = 10;
   localparam int TPM_MAG_W = 30;
   localparam int TPM_THR_W = 32;
   localparam int TPM_NUM_OUT = 4;
   localparam int TPM_ADDR_W = 5;
   localparam int TPM_MAP_CODES = 24;

   // Byte addresses
   localparam logic [TPM_ADDR_W-1:0] TPM_OFS_CTRL = 5'h00;
   localparam logic [TPM_ADDR_W-1:0] TPM_OFS_STATUS = 5'h04;
   localparam logic [TPM_ADDR_W-1:0] TPM_OFS_THR0 = 5'h08;
   localparam logic [TPM_ADDR_W-1:0] TPM_OFS_THR1 = 5'h0c;
   localparam logic [TPM_ADDR_W-1:0] TPM_OFS_THR2 = 5'h10;
   localparam logic [TPM_ADDR_W-1:0] TPM_OFS_THR3 = 5'h14;

   // Control register fields
   localparam int TPM_CTRL_SIGN_LSB = 0;
   localparam int TPM_CTRL_MAP_LSB = 4;
   localparam int TPM_CTRL_SUM_BIT = 9;
   localparam int TPM_CTRL_EN_LSB = 10;
   localparam int TPM_CTRL_REFRESH_BIT = 31;

   // Status register fields
   localparam int TPM_STAT_BUSY_BIT = 0;
   localparam int TPM_STAT_PEND_BIT = 1;
   localparam int TPM_STAT_OUT_LSB = 4;
   localparam int TPM_STAT_CNT_LSB = 8;

   // Reset values
   localparam logic [3:0] TPM_SIGN_RST = 4'h0;
   localparam logic [4:0] TPM_MAP_RST = 5'h00;
   localparam logic [6:0] TPM_REFRESH_EN_RST = 7'h01;
   localparam logic [TPM_THR_W-1:0] TPM_THR_RST = 32'h0000_0000;
   // Clock cycles until synchronised pins are valid after reset
   localparam logic [1:0] TPM_SYNC_FILL = 2'h2;

   // Entry: output index for set 1 in [7:6], set 2 [5:4], set 3 [3:2], set 4 [1:0]
   localparam logic [TPM_MAP_CODES-1:0][7:0] TPM_MAP_TABLE = {
      8'he4, 8'he1, 8'hd2, 8'hd8, 8'hc9, 8'hc6,
      8'hb4, 8'hb1, 8'h93, 8'h9c, 8'h8d, 8'h87,
      8'h78, 8'h72, 8'h63, 8'h6c, 8'h4e, 8'h4b,
      8'h39, 8'h36, 8'h27, 8'h2d, 8'h1e, 8'h1b};
endpackage

// ==== rtl/tpm_top.sv ====
// Thumbwheel capture, sign and output mapping with threshold comparators
//
// Added by the designer: the register offsets and the Avalon-MM slave port.
`timescale 1ns/100ps
`default_nettype none
module tpm_top
   import tpm_pkg::*;
#(
   parameter int NS = TPM_NUM_SETS_DEF,
   parameter int ND = TPM_DIGITS_DEF
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [TPM_ADDR_W-1:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   input wire logic [2:0] keyIn,
   input wire logic [3:0] ctrlIn,
   input wire logic [NS-1:0][ND-1:0][3:0] thumbDigits,
   input wire logic [TPM_THR_W-1:0] count1,
   input wire logic [TPM_THR_W-1:0] count2,
   input wire logic [1:0] presetSel,
   output logic [TPM_NUM_OUT-1:0][TPM_THR_W-1:0] thresholdOut,
   output logic [TPM_NUM_OUT-1:0] highSpeedOut,
   output logic [TPM_NUM_OUT-1:0] relayOut,
   output logic [TPM_THR_W-1:0] presetValue
);
   if (NS != 2 && NS != 4) begin : gBadSets
      $error("tpm_top: NS must be 2 or 4");
   end
   // Nine digits and one blank within ten positions
   if (ND < 1 || ND > TPM_MAX_DIGITS || ND + 1 > TPM_ROW_POSITIONS) begin : gBadDigits
      $error("tpm_top: ND out of range");
   end
   // Sign handling needs two spare bits above the magnitude
   if (TPM_THR_W != TPM_MAG_W + 2) begin : gBadWidth
      $error("tpm_top: threshold width must be magnitude width plus two");
   end
   // Table entries hold four two-bit output indices
   if (TPM_NUM_OUT != 4) begin : gBadOut
      $error("tpm_top: the map table serves exactly four outputs");
   end
   // Every map entry must send the sets to distinct outputs
   for (genvar c = 0; c < TPM_MAP_CODES; c++) begin : gMapCheck
      for (genvar a = 0; a < TPM_NUM_OUT; a++) begin : gFirst
         for (genvar b = a + 1; b < TPM_NUM_OUT; b++) begin : gSecond
            if (TPM_MAP_TABLE[c][7-2*a -: 2] == TPM_MAP_TABLE[c][7-2*b -: 2]) begin : gClash
               $error("tpm_top: map entry is not a permutation");
            end
         end
      end
   end

   typedef struct packed {
      logic [2:0] keySync1;
      logic [2:0] keySync2;
      logic [2:0] keyPrev;
      logic [3:0] inSync1;
      logic [3:0] inSync2;
      logic [3:0] inPrev;
      logic [NS-1:0][ND-1:0][3:0] digSync1;
      logic [NS-1:0][ND-1:0][3:0] digSync2;
      logic [3:0] signMask;
      logic [4:0] outMap;
      logic sumMode;
      logic [6:0] refreshEn;
      logic pending;
      logic start;
      logic [TPM_NUM_OUT-1:0][TPM_THR_W-1:0] thr;
      logic [TPM_NUM_OUT-1:0] hsOut;
      logic [TPM_NUM_OUT-1:0] relay;
      logic [TPM_THR_W-1:0] preset;
      logic waitReq;
      logic [31:0] rdData;
      logic [7:0] capCount;
      logic [1:0] warm;
   } tpm_state_t;

   tpm_state_t q, d;

   tpm_conv_if #(.NS(NS), .ND(ND), .MW(TPM_MAG_W)) convBus ();

   logic [TPM_NUM_OUT-1:0][1:0] setDest;
   logic mapValid;
   logic [4:0] mapCode;
   logic [TPM_NUM_OUT-1:0][TPM_MAG_W-1:0] magAll;

   tpm_bcd_conv #(
      .NS(NS),
      .ND(ND)
   ) uConv (
      .clk(clk),
      .nrst(nrst),
      .conv(convBus.cnv)
   );

   // Decoder follows the stored code; written codes are range-checked apart
   assign mapCode = q.outMap;

   tpm_perm_map uPerm (
      .code(mapCode),
      .dest(setDest),
      .valid(mapValid)
   );

   for (genvar g = 0; g < TPM_NUM_OUT; g++) begin : gMag
      if (g < NS) begin : gPresent
         assign magAll[g] = convBus.mag[g];
      end else begin : gAbsent
         assign magAll[g] = '0;
      end
   end

   assign convBus.start = q.start;
   assign convBus.digits = q.digSync2;

   always_comb begin
      logic access;
      logic refreshCmd;
      logic trig;
      logic [TPM_THR_W-1:0] val;
      logic [TPM_THR_W-1:0] cmpSum;
      logic [TPM_NUM_OUT-1:0][TPM_THR_W-1:0] cmpSrc;
      logic [TPM_NUM_OUT-1:0][1:0] destNow;
      logic commit;
      logic converting;
      logic [4:0] newMap;
      access = 1'b0;
      commit = 1'b0;
      converting = 1'b0;
      newMap = '0;
      refreshCmd = 1'b0;
      trig = 1'b0;
      val = '0;
      cmpSum = '0;
      cmpSrc = '0;
      destNow = setDest;
      d = q;

      // Pins pass two flops before use
      d.keySync1 = keyIn;
      d.keySync2 = q.keySync1;
      d.keyPrev = q.keySync2;
      d.inSync1 = ctrlIn;
      d.inSync2 = q.inSync1;
      d.inPrev = q.inSync2;
      d.digSync1 = thumbDigits;
      d.digSync2 = q.digSync1;

      // One wait cycle, then a single-cycle answer
      access = (read || write) && q.waitReq;
      d.waitReq = !access;
      // Writes land on the edge where the master sees waitrequest low
      commit = write && !q.waitReq;
      newMap = writedata[TPM_CTRL_MAP_LSB +: 5];
      // Start and done cycles read as converting, so polls see no gap
      converting = q.start || convBus.busy || convBus.done;
      if (commit) begin
         if (address == TPM_OFS_CTRL) begin
            d.signMask = writedata[TPM_CTRL_SIGN_LSB +: 4];
            if (newMap < 5'(TPM_MAP_CODES)) begin
               d.outMap = newMap;
            end
            d.sumMode = writedata[TPM_CTRL_SUM_BIT];
            d.refreshEn = writedata[TPM_CTRL_EN_LSB +: 7];
            refreshCmd = writedata[TPM_CTRL_REFRESH_BIT];
         end
      end
      if (access && read) begin
         unique case (address)
            TPM_OFS_CTRL: begin
               d.rdData = {15'h0000, q.refreshEn, q.sumMode, q.outMap, q.signMask};
            end
            TPM_OFS_STATUS: begin
               d.rdData = {16'h0000, q.capCount, q.hsOut, 2'b00, q.pending, converting};
            end
            TPM_OFS_THR0: begin
               d.rdData = q.thr[0];
            end
            TPM_OFS_THR1: begin
               d.rdData = q.thr[1];
            end
            TPM_OFS_THR2: begin
               d.rdData = q.thr[2];
            end
            TPM_OFS_THR3: begin
               d.rdData = q.thr[3];
            end
            default: begin
               d.rdData = 32'h0000_0000;
            end
         endcase
      end

      // Rising edge of an enabled key or input
      trig = |({q.inSync2 & ~q.inPrev, q.keySync2 & ~q.keyPrev} & q.refreshEn);

      // Hold the first capture until the digit synchroniser shows the pins
      if (q.warm != TPM_SYNC_FILL) begin
         d.warm = q.warm + 2'h1;
      end
      // Launch clears pending; a new request in that cycle wins
      d.start = 1'b0;
      if (q.pending && q.warm == TPM_SYNC_FILL && !convBus.busy && !q.start) begin
         d.start = 1'b1;
         d.pending = 1'b0;
      end
      if (trig || refreshCmd) begin
         d.pending = 1'b1;
      end

      // All thresholds load in the done cycle
      if (convBus.done) begin
         for (int s = 0; s < TPM_NUM_OUT; s++) begin
            val = {2'b00, magAll[s]};
            if (q.signMask[s]) begin
               val = TPM_THR_W'(-val);
            end
            d.thr[mapValid ? destNow[s] : 2'(s)] = val;
         end
         d.capCount = q.capCount + 8'h01;
      end

      // Outputs 3 and 4 see the sum in sum mode
      cmpSum = q.sumMode ? TPM_THR_W'(count1 + count2) : count2;
      cmpSrc[0] = count1;
      cmpSrc[1] = count1;
      cmpSrc[2] = cmpSum;
      cmpSrc[3] = cmpSum;
      for (int k = 0; k < TPM_NUM_OUT; k++) begin
         d.hsOut[k] = ($signed(cmpSrc[k]) >= $signed(q.thr[k]));
      end
      d.relay = d.hsOut;

      d.preset = q.thr[presetSel];
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         q <= '0;
         q.signMask <= TPM_SIGN_RST;
         q.outMap <= TPM_MAP_RST;
         q.refreshEn <= TPM_REFRESH_EN_RST;
         q.thr <= {TPM_NUM_OUT{TPM_THR_RST}};
         q.waitReq <= 1'b1;
         q.pending <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign readdata = q.rdData;
   assign waitrequest = q.waitReq;
   assign thresholdOut = q.thr;
   assign highSpeedOut = q.hsOut;
   assign relayOut = q.relay;
   assign presetValue = q.preset;
endmodule
`default_nettype wire

// ==== tb/tpm_panel.sv ====
// Front panel model: thumbwheel digits, keys and control inputs
`timescale 1ns/100ps
`default_nettype none
module tpm_panel #(
   parameter int NS = 4,
   parameter int ND = 9
) (
   input wire logic clk,
   input wire logic [NS-1:0][31:0] setVal,
   output logic [NS-1:0][ND-1:0][3:0] thumbDigits,
   output logic [2:0] keyIn,
   output logic [3:0] ctrlIn
);
   logic [6:0] btn = 7'h00;
   int unsigned v;
   assign keyIn = btn[2:0];
   assign ctrlIn = btn[6:3];
   always_comb begin
      for (int s = 0; s < NS; s++) begin
         v = setVal[s];
         for (int d = 0; d < ND; d++) begin
            thumbDigits[s][d] = 4'(v % 10);
            v = v / 10;
         end
      end
   end
   task automatic press(input int i);
      @(posedge clk);
      btn[i] <= 1'b1;
      repeat (5) @(posedge clk);
      btn <= 7'h00;
   endtask
endmodule
`default_nettype wire

// ==== tb/tpm_sva.sv ====
// Checker for bus timing, relays and threshold outputs
`timescale 1ns/100ps
`default_nettype none
module tpm_sva
   import tpm_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic [TPM_ADDR_W-1:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] readdata,
   input wire logic waitrequest,
   input wire logic [2:0] keyIn,
   input wire logic [3:0] ctrlIn,
   input wire logic [TPM_THR_W-1:0] count1,
   input wire logic [1:0] presetSel,
   input wire logic [TPM_NUM_OUT-1:0][TPM_THR_W-1:0] thresholdOut,
   input wire logic [TPM_NUM_OUT-1:0] highSpeedOut,
   input wire logic [TPM_NUM_OUT-1:0] relayOut,
   input wire logic [TPM_THR_W-1:0] presetValue
);
   logic [7:0] quiet_q;
   logic [31:0] pick;
   logic [31:0] thr0;
   logic [31:0] thr1;
   assign pick = thresholdOut[presetSel];
   assign thr0 = thresholdOut[0];
   assign thr1 = thresholdOut[1];
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   // Cycles since the last possible refresh cause
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) quiet_q <= 8'h00;
      else if (keyIn != 3'h0 || ctrlIn != 4'h0 || write) quiet_q <= 8'h00;
      else if (quiet_q != 8'hff) quiet_q <= quiet_q + 8'h01;
   end
   a_relay_follow: assert property (relayOut == highSpeedOut) else $error("relay differs");
   a_wait_answer: assert property ((read || write) && waitrequest |=> !waitrequest) else $error("no answer");
   a_wait_one: assert property (!waitrequest |=> waitrequest) else $error("long answer");
   a_cmp_first: assert property ($past(nrst) |->
      highSpeedOut[0] == ($signed($past(count1)) >= $signed($past(thr0)))) else $error("compare 1 wrong");
   a_cmp_second: assert property ($past(nrst) |->
      highSpeedOut[1] == ($signed($past(count1)) >= $signed($past(thr1)))) else $error("compare 2 wrong");
   a_preset_pick: assert property ($past(nrst) |-> presetValue == $past(pick)) else $error("preset wrong");
   a_thr_hold: assert property (quiet_q > 8'h1e |-> $stable(thresholdOut)) else $error("threshold moved");
   a_thr_read: assert property (read && waitrequest && address == TPM_OFS_THR0 |=>
      readdata == $past(thr0)) else $error("read wrong");
   a_unmapped_zero: assert property (read && waitrequest && address == 5'h18 |=> readdata == 32'h0)
      else $error("unmapped not zero");
endmodule
`default_nettype wire

// ==== tb/tpm_top_tb.sv ====
// Testbench for the thumbwheel preset mapper
`timescale 1ns/100ps
`default_nettype none
module tpm_top_tb;
   import tpm_pkg::*;
   localparam int NS = 4;
   localparam int ND = 9;
   localparam string MAPS = {"123412431342132414231432213421432341231424132431",
      "312431423241321434123421412341324231421343124321"};
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [TPM_ADDR_W-1:0] address = '0;
   logic [31:0] writedata = '0;
   logic [31:0] readdata, rd;
   logic waitrequest;
   logic [2:0] keyIn;
   logic [3:0] ctrlIn;
   logic [NS-1:0][ND-1:0][3:0] thumbDigits;
   logic [NS-1:0][31:0] setVal = {32'h50, 32'h11d7, 32'h1, 32'h3b9ac9ff};
   logic [31:0] count1 = '0;
   logic [31:0] count2 = '0;
   logic [1:0] presetSel = '0;
   logic [TPM_NUM_OUT-1:0][31:0] thresholdOut;
   logic [TPM_NUM_OUT-1:0] highSpeedOut, relayOut;
   logic [31:0] presetValue;
   int n_fail = 0;
   int tests_run = 0;
   int cyc = 0;
   tpm_top #(.NS(NS), .ND(ND)) tpm_top_inst (.clk(clk), .nrst(nrst), .address(address), .read(read),
      .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .keyIn(keyIn),
      .ctrlIn(ctrlIn), .thumbDigits(thumbDigits), .count1(count1), .count2(count2), .presetSel(presetSel),
      .thresholdOut(thresholdOut), .highSpeedOut(highSpeedOut), .relayOut(relayOut), .presetValue(presetValue));
   tpm_panel #(.NS(NS), .ND(ND)) tpm_panel_inst (.clk(clk), .setVal(setVal), .thumbDigits(thumbDigits),
      .keyIn(keyIn), .ctrlIn(ctrlIn));
   initial begin
      forever #5 clk = ~clk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic wr, input logic [TPM_ADDR_W-1:0] a, input logic [31:0] d);
      @(posedge clk);
      read <= !wr;
      write <= wr;
      address <= a;
      writedata <= d;
      do @(posedge clk); while (waitrequest !== 1'b0);
      rd = readdata;
      read <= 1'b0;
      write <= 1'b0;
   endtask
   task automatic settle();
      repeat (8) @(posedge clk);
      do bus(1'b0, TPM_OFS_STATUS, 32'h0); while (rd[1:0] !== 2'h0);
      repeat (2) @(posedge clk);
   endtask
   task automatic cmp_map(input logic [3:0] m, input int c);
      int o;
      for (int s = 0; s < 4; s++) begin
         o = int'(MAPS[c*4+s]) - 49;
         chk(thresholdOut[o], m[s] ? -setVal[s] : setVal[s]);
      end
   endtask
   task automatic t_powerup();
      settle();
      for (int s = 0; s < 4; s++) begin
         bus(1'b0, TPM_OFS_THR0 + 5'(4*s), 32'h0);
         chk(rd, setVal[s]);
      end
      bus(1'b0, 5'h18, 32'h0);
      chk(rd, 32'h0);
   endtask
   task automatic t_refresh();
      logic [NS-1:0][31:0] old;
      old = setVal;
      setVal[1] <= 32'h2710;
      repeat (40) @(posedge clk);
      chk(thresholdOut[1], old[1]);
      tpm_panel_inst.press(0);
      settle();
      chk(thresholdOut[1], 32'h2710);
      bus(1'b1, TPM_OFS_CTRL, 32'h8000);
      setVal[2] <= 32'h7;
      tpm_panel_inst.press(0);
      repeat (20) @(posedge clk);
      chk(thresholdOut[2], old[2]);
      tpm_panel_inst.press(5);
      settle();
      chk(thresholdOut[2], 32'h7);
   endtask
   task automatic t_map_sign();
      for (int c = 0; c < 25; c++) begin
         bus(1'b1, TPM_OFS_CTRL, 32'h8000_8000 | (32'(c) << 4) | 32'(c % 16));
         settle();
         cmp_map(4'(c % 16), (c < 24) ? c : 23);
      end
      bus(1'b0, TPM_OFS_CTRL, 32'h0);
      chk(rd, 32'h0000_8008 | (32'd23 << TPM_CTRL_MAP_LSB));
   endtask
   task automatic t_sum();
      bus(1'b1, TPM_OFS_CTRL, 32'h8000_8000);
      settle();
      count1 <= 32'h4;
      count2 <= 32'h3;
      presetSel <= 2'h2;
      repeat (3) @(posedge clk);
      chk(presetValue, 32'h7);
      chk(highSpeedOut, 32'h0);
      bus(1'b1, TPM_OFS_CTRL, 32'h8200);
      repeat (3) @(posedge clk);
      chk(highSpeedOut, 32'h4);
      chk(relayOut, 32'h4);
   endtask
   task automatic print_verdict();
      $display("checks=%0d mismatches=%0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         n_fail++;
         print_verdict();
      end
   end
   initial begin
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
      t_powerup();
      t_refresh();
      t_map_sign();
      t_sum();
      print_verdict();
   end
endmodule
bind tpm_top tpm_sva tpm_sva_inst (.clk(clk), .nrst(nrst), .address(address), .read(read), .write(write),
   .readdata(readdata), .waitrequest(waitrequest), .keyIn(keyIn), .ctrlIn(ctrlIn), .count1(count1),
   .presetSel(presetSel), .thresholdOut(thresholdOut), .highSpeedOut(highSpeedOut), .relayOut(relayOut),
   .presetValue(presetValue));
`default_nettype wire
